// ---- verilog/rx_timers_pkg.sv ----
package rx_timers_pkg;
	// Register indices; byte address is four times the index
	localparam int              ADDR_W            = 8;
	localparam logic [5:0]      IDX_RX_MASK_TIME  = 6'h0f;
	localparam logic [5:0]      IDX_NRT_HIGH      = 6'h10;
	localparam logic [5:0]      IDX_NRT_LOW       = 6'h11;
	localparam logic [5:0]      IDX_TIMER_CONTROL = 6'h12;
	localparam logic [5:0]      IDX_GPT_TIME      = 6'h20;
	localparam logic [5:0]      IDX_MODE          = 6'h21;
	localparam logic [5:0]      IDX_COMMAND       = 6'h22;
	localparam logic [5:0]      IDX_INT_STATUS    = 6'h23;
	localparam logic [5:0]      IDX_INT_MASK      = 6'h24;
	localparam logic [5:0]      IDX_TIMER_STATUS  = 6'h25;

	// Reset values
	localparam logic [7:0]      RX_MASK_TIME_RST  = 8'h08;
	localparam logic [7:0]      ZERO8             = 8'h00;

	// Timer control fields
	localparam int              TC_TRIG_LSB       = 5;
	localparam int              TC_MRT_STEP       = 3;
	localparam int              TC_START_COND     = 2;
	localparam int              TC_PAYMENT        = 1;
	localparam int              TC_NRT_STEP       = 0;
	localparam logic [7:0]      TC_WRITABLE       = 8'hef;

	// Mode, command and interrupt bits
	localparam int              MODE_NFC          = 0;
	localparam int              MODE_ACTIVE_PEER  = 1;
	localparam int              CMD_START_NRT     = 0;
	localparam int              CMD_START_GPT     = 1;
	localparam int              INT_W             = 3;
	localparam int              INT_NRT           = 0;
	localparam int              INT_GPT           = 1;
	localparam int              INT_MASK_END      = 2;

	// Steps as shifts of carrier periods: 64, 512, 4096 and 8
	localparam int              MRT_SHIFT0        = 6;
	localparam int              MRT_SHIFT1        = 9;
	localparam int              NRT_SHIFT0        = 6;
	localparam int              NRT_SHIFT1        = 12;
	localparam int              GPT_SHIFT         = 3;

	// Trigger sources
	localparam logic [2:0]      TRIG_NONE         = 3'h0;
	localparam logic [2:0]      TRIG_RX_END       = 3'h1;
	localparam logic [2:0]      TRIG_RX_START     = 3'h2;
	localparam logic [2:0]      TRIG_TX_END       = 3'h3;

	typedef enum logic [1:0] {
		NRT_IDLE       = 2'b00,
		NRT_WAIT_FIELD = 2'b01,
		NRT_RUN        = 2'b11
	} nrt_state_t;
endpackage

// ---- verilog/rx_timers.sv ----
// Function
// - Receiver output is ignored for the mask time after transmission ends.
// - Mask step select 0: each mask count is 64 carrier periods.
// - Mask step select 1: each mask count is 512 carrier periods.
// - No-response timer runs from end of transmission; expiry without reply interrupts.
// - In NFC mode the no-response timer starts only once external field seen, except by start command.
// - Active peer: no-response timer starts when own transmitter switches off.
// - A zero no-response value never starts the no-response timer.
// - Start command resets and restarts the no-response timer.
// - No-response step select: 64 carrier periods when 0, 4096 when 1.
// - No-response value is 16 bits: high byte at 10h, low at 11h.
// - Active peer start condition: 0 own field off, 1 peer field on.
// - Payment-mode bit selects the payment variant of the no-response timer.
// - General purpose timer starts on its start command when its time value is nonzero.
// - Trigger field adds end of reception, start of reception or end of transmission.
// - Trigger 011 in active peer: expiry switches field off, gates timer start.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module rx_timers
	import rx_timers_pkg::*;
#(
	parameter int GPT_W = 16
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Carrier and front end events
	input  wire logic              carrier_tick,
	input  wire logic              tx_end,
	input  wire logic              rx_start,
	input  wire logic              rx_end,
	input  wire logic              ext_field,
	input  wire logic              peer_field_on,
	input  wire logic              response_detected,
	// Receiver data path
	input  wire logic              rx_data_in,
	output logic                   rx_data_out,
	// Field control and interrupt
	output logic                   field_off,
	output logic                   irq
);
	localparam int MASK_CW = 8 + MRT_SHIFT1;
	localparam int NRT_CW  = 16 + NRT_SHIFT1;
	localparam int GPT_CW  = GPT_W + GPT_SHIFT;

	if (GPT_W < 8 || GPT_W > 16) begin : g_bad_width
		$error("GPT_W must lie between 8 and 16");
	end

	typedef struct packed {
		logic [7:0]        rx_mask_time;
		logic [7:0]        nrt_high;
		logic [7:0]        nrt_low;
		logic [7:0]        timer_control;
		logic [GPT_W-1:0]  gpt_time;
		logic [1:0]        mode;
		logic [INT_W-1:0]  int_status;
		logic [INT_W-1:0]  int_mask;
		logic [MASK_CW-1:0] mask_cnt;
		nrt_state_t        nrt_state;
		logic [NRT_CW-1:0] nrt_cnt;
		logic [GPT_CW-1:0] gpt_cnt;
		logic              gpt_run;
		logic              rx_data_out;
		logic              field_off;
		logic              irq;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} state_t;

	function automatic logic is_mapped(input logic [5:0] idx);
		case (idx)
			IDX_RX_MASK_TIME, IDX_NRT_HIGH, IDX_NRT_LOW, IDX_TIMER_CONTROL,
			IDX_GPT_TIME, IDX_MODE, IDX_COMMAND, IDX_INT_STATUS,
			IDX_INT_MASK, IDX_TIMER_STATUS: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	state_t          s;
	state_t          next_s;
	logic [5:0]      idx;
	logic            acc;
	logic            wr_go;
	logic            cmd_nrt;
	logic            cmd_gpt;
	logic [INT_W-1:0] w1c;
	logic [INT_W-1:0] events;
	logic [2:0]      trig;
	logic            active_peer_mode;
	logic            eot_gpt;
	logic [15:0]     nrt_val;
	logic [NRT_CW-1:0] nrt_load;
	logic            resp;
	logic            gpt_load;
	logic            gpt_exp;
	logic            nrt_exp;
	logic            own_off;
	logic            auto_start;
	logic            nrt_start;
	logic            nrt_wait;

	always_comb begin
		next_s = s;
		next_s.field_off = 1'b0;
		idx = paddr[7:2];
		acc = psel & penable;
		wr_go = acc & s.pready & pwrite;
		cmd_nrt = 1'b0;
		cmd_gpt = 1'b0;
		w1c = '0;
		events = '0;
		trig = s.timer_control[TC_TRIG_LSB+:3];
		active_peer_mode = s.mode[MODE_ACTIVE_PEER];
		eot_gpt = active_peer_mode && trig == TRIG_TX_END;
		nrt_val = {s.nrt_high, s.nrt_low};
		nrt_load = s.timer_control[TC_NRT_STEP] ? {nrt_val, 12'h000}
			: {6'h00, nrt_val, 6'h00};
		// Responses inside the mask window are not seen by the timer
		resp = response_detected && s.mask_cnt == '0;
		gpt_exp = 1'b0;
		nrt_exp = 1'b0;

		// APB: answer in the cycle after the access phase opens
		next_s.pready = acc & ~s.pready;
		// Error flag stands only in the cycle that pready does
		next_s.pslverr = 1'b0;
		if (acc && !s.pready) begin
			next_s.pslverr = ~is_mapped(idx);
			next_s.prdata = '0;
			if (!pwrite) begin
				case (idx)
					IDX_RX_MASK_TIME:  next_s.prdata[7:0] = s.rx_mask_time;
					IDX_NRT_HIGH:      next_s.prdata[7:0] = s.nrt_high;
					IDX_NRT_LOW:       next_s.prdata[7:0] = s.nrt_low;
					IDX_TIMER_CONTROL: next_s.prdata[7:0] = s.timer_control;
					IDX_GPT_TIME:      next_s.prdata[GPT_W-1:0] = s.gpt_time;
					IDX_MODE:          next_s.prdata[1:0] = s.mode;
					IDX_INT_STATUS:    next_s.prdata[INT_W-1:0] = s.int_status;
					IDX_INT_MASK:      next_s.prdata[INT_W-1:0] = s.int_mask;
					IDX_TIMER_STATUS:  next_s.prdata[3:0] = {s.nrt_state, s.gpt_run,
						s.mask_cnt != '0};
					default:           next_s.prdata = '0;
				endcase
			end
		end
		if (wr_go) begin
			case (idx)
				IDX_RX_MASK_TIME:  next_s.rx_mask_time = pwdata[7:0];
				IDX_NRT_HIGH:      next_s.nrt_high = pwdata[7:0];
				IDX_NRT_LOW:       next_s.nrt_low = pwdata[7:0];
				IDX_TIMER_CONTROL: next_s.timer_control = pwdata[7:0] & TC_WRITABLE;
				IDX_GPT_TIME:      next_s.gpt_time = pwdata[GPT_W-1:0];
				IDX_MODE:          next_s.mode = pwdata[1:0];
				IDX_COMMAND: begin
					cmd_nrt = pwdata[CMD_START_NRT];
					cmd_gpt = pwdata[CMD_START_GPT];
				end
				IDX_INT_STATUS:    w1c = pwdata[INT_W-1:0];
				IDX_INT_MASK:      next_s.int_mask = pwdata[INT_W-1:0];
				default: ;
			endcase
		end

		// Mask receive timer
		if (tx_end) begin
			next_s.mask_cnt = s.timer_control[TC_MRT_STEP] ? {s.rx_mask_time, 9'h000}
				: {3'h0, s.rx_mask_time, 6'h00};
		end else if (carrier_tick && s.mask_cnt != '0) begin
			next_s.mask_cnt = s.mask_cnt - 1'b1;
			events[INT_MASK_END] = s.mask_cnt == 1;
		end
		next_s.rx_data_out = (s.mask_cnt != '0) ? 1'b0 : rx_data_in;

		// General purpose timer
		gpt_load = cmd_gpt
			|| (trig == TRIG_RX_END && rx_end)
			|| (trig == TRIG_RX_START && rx_start)
			|| (trig == TRIG_TX_END && tx_end);
		if (gpt_load && s.gpt_time != '0) begin
			next_s.gpt_cnt = {s.gpt_time, 3'h0};
			next_s.gpt_run = 1'b1;
		end else if (s.gpt_run && carrier_tick) begin
			next_s.gpt_cnt = s.gpt_cnt - 1'b1;
			if (s.gpt_cnt == 1) begin
				gpt_exp = 1'b1;
				next_s.gpt_run = 1'b0;
			end
		end
		events[INT_GPT] = gpt_exp;
		next_s.field_off = gpt_exp & eot_gpt;

		// No-response timer start selection
		own_off = eot_gpt ? gpt_exp : tx_end;
		if (active_peer_mode) begin
			auto_start = s.timer_control[TC_START_COND] ? peer_field_on : own_off;
		end else begin
			auto_start = tx_end && (!s.mode[MODE_NFC] || ext_field);
		end
		nrt_start = nrt_val != '0 && (cmd_nrt || auto_start);
		nrt_wait = nrt_val != '0 && !active_peer_mode && s.mode[MODE_NFC]
			&& tx_end && !ext_field;

		if (nrt_start) begin
			next_s.nrt_state = NRT_RUN;
			next_s.nrt_cnt = nrt_load;
		end else if (nrt_wait) begin
			next_s.nrt_state = NRT_WAIT_FIELD;
		end else begin
			case (s.nrt_state)
				NRT_WAIT_FIELD: begin
					// A value cleared while waiting must not start a zero count
					if (ext_field && nrt_val != '0) begin
						next_s.nrt_state = NRT_RUN;
						next_s.nrt_cnt = nrt_load;
					end
				end
				NRT_RUN: begin
					// Payment variant keeps timing through a reply
					if (resp && !s.timer_control[TC_PAYMENT]) begin
						next_s.nrt_state = NRT_IDLE;
					end else if (carrier_tick) begin
						next_s.nrt_cnt = s.nrt_cnt - 1'b1;
						if (s.nrt_cnt == 1) begin
							nrt_exp = 1'b1;
							next_s.nrt_state = NRT_IDLE;
						end
					end
				end
				default: next_s.nrt_state = NRT_IDLE;
			endcase
		end
		events[INT_NRT] = nrt_exp;

		// Set wins over a write-one clear in the same cycle
		next_s.int_status = (s.int_status & ~w1c) | events;
		next_s.irq = |(next_s.int_status & next_s.int_mask);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.rx_mask_time <= RX_MASK_TIME_RST;
			s.nrt_high <= ZERO8;
			s.nrt_low <= ZERO8;
			s.timer_control <= ZERO8;
			s.nrt_state <= NRT_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign pready      = s.pready;
	assign prdata      = s.prdata;
	assign pslverr     = s.pslverr;
	assign rx_data_out = s.rx_data_out;
	assign field_off   = s.field_off;
	assign irq         = s.irq;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_mask_blank;
		s.mask_cnt != '0 |=> !rx_data_out;
	endproperty
	a_mask_blank: assert property (p_mask_blank)
		else $error("receiver output passed during mask time");

	property p_mask_step64;
		tx_end && !s.timer_control[TC_MRT_STEP] |=> s.mask_cnt == 64 * $past(s.rx_mask_time);
	endproperty
	a_mask_step64: assert property (p_mask_step64)
		else $error("mask load wrong for 64 period step");

	property p_mask_step512;
		tx_end && s.timer_control[TC_MRT_STEP] |=> s.mask_cnt == 512 * $past(s.rx_mask_time);
	endproperty
	a_mask_step512: assert property (p_mask_step512)
		else $error("mask load wrong for 512 period step");

	property p_nrt_expire;
		s.nrt_state == NRT_RUN && s.nrt_cnt == 1 && carrier_tick && !resp && !nrt_start
			&& !nrt_wait
			|=> s.int_status[INT_NRT] && s.nrt_state == NRT_IDLE;
	endproperty
	a_nrt_expire: assert property (p_nrt_expire)
		else $error("no-response expiry did not flag");

	property p_nrt_wait_field;
		nrt_wait && !cmd_nrt |=> s.nrt_state == NRT_WAIT_FIELD;
	endproperty
	a_nrt_wait_field: assert property (p_nrt_wait_field)
		else $error("no-response timer started without external field");

	property p_nrt_zero;
		nrt_val == '0 && s.nrt_state == NRT_IDLE |=> s.nrt_state == NRT_IDLE;
	endproperty
	a_nrt_zero: assert property (p_nrt_zero)
		else $error("no-response timer started from zero value");

	property p_nrt_restart;
		cmd_nrt && nrt_val != '0 |=> s.nrt_state == NRT_RUN
			&& s.nrt_cnt == ($past(s.timer_control[TC_NRT_STEP]) ? 4096 : 64) * $past(nrt_val);
	endproperty
	a_nrt_restart: assert property (p_nrt_restart)
		else $error("start command did not reload no-response timer");

	property p_ap_own_off;
		active_peer_mode && !s.timer_control[TC_START_COND] && !eot_gpt && tx_end
			&& nrt_val != '0 |=> s.nrt_state == NRT_RUN;
	endproperty
	a_ap_own_off: assert property (p_ap_own_off)
		else $error("active peer end of transmission did not start timer");

	property p_ap_peer_on;
		active_peer_mode && s.timer_control[TC_START_COND] && peer_field_on
			&& nrt_val != '0 |=> s.nrt_state == NRT_RUN;
	endproperty
	a_ap_peer_on: assert property (p_ap_peer_on)
		else $error("peer field on did not start no-response timer");

	property p_gpt_cmd;
		cmd_gpt && s.gpt_time != '0 |=> s.gpt_run ##0 s.gpt_cnt == 8 * $past(s.gpt_time);
	endproperty
	a_gpt_cmd: assert property (p_gpt_cmd)
		else $error("start command did not start general purpose timer");

	property p_gpt_field_off;
		gpt_exp && eot_gpt |=> field_off ##1 !field_off;
	endproperty
	a_gpt_field_off: assert property (p_gpt_field_off)
		else $error("field off pulse missing after timer expiry");

	c_nrt_expired: cover property (s.nrt_state == NRT_RUN ##1 s.int_status[INT_NRT]);
	c_nrt_answered: cover property (s.nrt_state == NRT_RUN && resp ##1 s.nrt_state == NRT_IDLE);
	c_field_off: cover property (field_off);
	c_irq: cover property (!irq ##1 irq);
endmodule

// ---- sim/tb_rx_timers.sv ----
`timescale 1ns/100ps
module tb_rx_timers;
	import rx_timers_pkg::*;
	logic        clock;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [4:0]  ev;
	logic        ext_field;
	logic        rx_data_in;
	logic        rx_data_out;
	logic        field_off;
	logic        irq;
	logic        b;
	logic        tick;
	logic        tick_slow;
	logic [32:0] exp_q[$];
	int          err_total;
	int          tests_run;
	int          seed;
	int          n;

	rx_timers uut (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.carrier_tick(tick), .tx_end(ev[0]), .rx_start(ev[1]), .rx_end(ev[2]),
		.ext_field(ext_field), .peer_field_on(ev[3]), .response_detected(ev[4]),
		.rx_data_in(rx_data_in), .rx_data_out(rx_data_out), .field_off(field_off), .irq(irq)
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Carrier every clock, or every other clock to prove counts follow the tick
	always @(posedge clock) begin
		tick <= (tick_slow === 1'b1 && tick === 1'b1) ? 1'b0 : 1'b1;
	end

	task automatic end_of_test();
		$display("Checks run %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Master holds everything until pready is seen high at an edge
	task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			err_total++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h0, d});
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] e);
		exp_q.push_back({25'h0, e});
		apb(1'b0, idx, 32'h0);
	endtask

	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clock);
		ev[i] <= 1'b0;
		@(posedge clock);
	endtask

	// Read results checked in order as they appear on the bus
	always @(posedge clock) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() > 0)
				chk({pslverr, prdata}, exp_q.pop_front());
			else
				chk({pslverr, prdata}, 33'h1ffffffff);
		end
	end

	initial begin
		seed = 32'h38e4dcbd;
		{psel, penable, pwrite, ext_field, rx_data_in} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ev = 5'h0;
		tick_slow = 1'b0;
		err_total = 0;
		tests_run = 0;
		rst_n = 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(IDX_RX_MASK_TIME, RX_MASK_TIME_RST);
		rd(IDX_TIMER_CONTROL, ZERO8);
		// Unmapped index answers with an error and zero data
		exp_q.push_back({1'b1, 32'h0});
		apb(1'b0, 6'h3e, 32'h0);
		wr(IDX_TIMER_CONTROL, 8'hff);
		rd(IDX_TIMER_CONTROL, 8'hef);
		// Mask at the minimum usable length, step 64 then 512
		wr(IDX_TIMER_CONTROL, 8'h00);
		wr(IDX_RX_MASK_TIME, 8'h04);
		rx_data_in <= 1'b1;
		pulse(0);
		repeat (230) @(posedge clock);
		chk(rx_data_out, 1'b0);
		repeat (40) @(posedge clock);
		chk(rx_data_out, 1'b1);
		rd(IDX_INT_STATUS, 8'h04);
		wr(IDX_INT_MASK, 8'h07);
		chk(irq, 1'b1);
		wr(IDX_INT_STATUS, 8'h07);
		chk(irq, 1'b0);
		wr(IDX_TIMER_CONTROL, 8'h08);
		pulse(0);
		repeat (2000) @(posedge clock);
		chk(rx_data_out, 1'b0);
		repeat (60) @(posedge clock);
		chk(rx_data_out, 1'b1);
		wr(IDX_RX_MASK_TIME, 8'h00);
		for (int i = 0; i < 16; i++) begin
			b = 1'($random(seed));
			rx_data_in <= b;
			@(posedge clock);
			@(posedge clock);
			chk(rx_data_out, b);
		end
		// No-response timer: zero value, step 64, step 4096
		wr(IDX_TIMER_CONTROL, 8'h00);
		wr(IDX_INT_STATUS, 8'h07);
		pulse(0);
		rd(IDX_TIMER_STATUS, 8'h00);
		wr(IDX_NRT_LOW, 8'h02);
		pulse(0);
		repeat (100) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h00);
		repeat (30) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h01);
		wr(IDX_INT_STATUS, 8'h07);
		pulse(0);
		repeat (40) @(posedge clock);
		pulse(4);
		repeat (150) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h00);
		wr(IDX_TIMER_CONTROL, 8'h02);
		pulse(0);
		repeat (40) @(posedge clock);
		pulse(4);
		repeat (150) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h01);
		wr(IDX_INT_STATUS, 8'h07);
		wr(IDX_TIMER_CONTROL, 8'h01);
		wr(IDX_NRT_LOW, 8'h00);
		wr(IDX_NRT_HIGH, 8'h01);
		rd(IDX_NRT_HIGH, 8'h01);
		pulse(0);
		repeat (30) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h00);
		wr(IDX_NRT_HIGH, 8'h00);
		wr(IDX_NRT_LOW, 8'h01);
		pulse(0);
		repeat (4000) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h00);
		repeat (150) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h01);
		// Command restarts a running count
		wr(IDX_TIMER_CONTROL, 8'h00);
		wr(IDX_NRT_LOW, 8'h02);
		wr(IDX_INT_STATUS, 8'h07);
		pulse(0);
		repeat (90) @(posedge clock);
		wr(IDX_COMMAND, 8'h01);
		repeat (100) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h00);
		repeat (40) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h01);
		// Start gated by field in NFC mode, by own or peer field in active peer
		wr(IDX_MODE, 8'h01);
		pulse(0);
		rd(IDX_TIMER_STATUS, 8'h04);
		ext_field <= 1'b1;
		repeat (3) @(posedge clock);
		rd(IDX_TIMER_STATUS, 8'h0c);
		repeat (140) @(posedge clock);
		wr(IDX_MODE, 8'h02);
		pulse(0);
		rd(IDX_TIMER_STATUS, 8'h0c);
		repeat (140) @(posedge clock);
		wr(IDX_TIMER_CONTROL, 8'h04);
		pulse(0);
		rd(IDX_TIMER_STATUS, 8'h00);
		pulse(3);
		rd(IDX_TIMER_STATUS, 8'h0c);
		repeat (140) @(posedge clock);
		// General purpose timer: command, then each trigger source
		wr(IDX_MODE, 8'h00);
		wr(IDX_NRT_LOW, 8'h00);
		wr(IDX_GPT_TIME, 8'h04);
		wr(IDX_INT_STATUS, 8'h07);
		// Half-rate carrier: 32 ticks now take 64 clocks
		tick_slow <= 1'b1;
		wr(IDX_COMMAND, 8'h02);
		rd(IDX_TIMER_STATUS, 8'h02);
		repeat (40) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h00);
		repeat (30) @(posedge clock);
		rd(IDX_INT_STATUS, 8'h02);
		tick_slow <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			wr(IDX_TIMER_CONTROL, {c[2:0], 5'h00});
			pulse(c == 1 ? 2 : (c == 2 ? 1 : 0));
			rd(IDX_TIMER_STATUS, c == 0 ? 8'h00 : 8'h02);
			repeat (40) @(posedge clock);
		end
		wr(IDX_MODE, 8'h02);
		wr(IDX_TIMER_CONTROL, 8'h60);
		wr(IDX_NRT_LOW, 8'h02);
		pulse(0);
		rd(IDX_TIMER_STATUS, 8'h02);
		n = 0;
		while (field_off !== 1'b1 && n < 60) begin
			@(posedge clock);
			n++;
		end
		chk(field_off, 1'b1);
		repeat (3) @(posedge clock);
		rd(IDX_TIMER_STATUS, 8'h0c);
		end_of_test();
	end
endmodule
